// File: hw/tcm_monitor.sv
// torque cutoff monitor with self-test, indicator leds and apb registers
//
// What this block does
// RQ1: motor runs only while both inputs high
// RQ2: self-test at power-on and both-high rise
// RQ3: motor energised only after passing self-test
// RQ4: failed test or inputs not both high cut power
// RQ5: one input high alarms; both low no alarm
// RQ6: bypassed by default; needs enable and jumper removed
// RQ7: comm led shows usb and can state
// RQ8: status led blinks every two seconds
// RQ9: power led on once powered up
// RQ10: safety circuit drives both inputs together
// RQ11: cutoff inputs pass two synchronising flops
`timescale 1ns/10ps
`default_nettype none
module tcm_monitor
    import tcm_pkg::*;
#(
    parameter int unsigned SELFTEST_CYC = tcm_pkg::SELFTEST_CYCLES,
    parameter int unsigned STATUS_CYC   = tcm_pkg::STATUS_PERIOD_CYC,
    parameter int unsigned COMM_CYC     = tcm_pkg::COMM_PERIOD_CYC
) (
    input  wire logic                      clock,                 // 25 MHz
    input  wire logic                      reset,                 // async, active high
    input  wire logic [tcm_pkg::ADDR_W-1:0] paddr,                // apb address
    input  wire logic                      psel,                  // apb select
    input  wire logic                      penable,               // apb access phase
    input  wire logic                      pwrite,                // apb direction
    input  wire logic [31:0]               pwdata,                // apb write data
    output logic      [31:0]               prdata,                // apb read data
    output logic                           pready,                // apb ready
    output logic                           pslverr,               // apb error
    input  wire logic                      torque_cutoff_in_a,    // cutoff pin a
    input  wire logic                      torque_cutoff_in_b,    // cutoff pin b
    input  wire logic                      bypass_jumper,         // high while jumper fitted
    input  wire logic                      stage_off_fb,          // power stage reports off
    input  wire logic                      usb_active,            // usb link up
    input  wire logic                      can_enabled,           // can link enabled
    output logic                           motor_enable,          // power stage enable
    output logic                           cutoff_mismatch_alarm, // inputs disagree
    output logic                           power_led,             // green power led
    output logic                           status_led_green,      // status led green
    output logic                           status_led_red,        // status led red
    output logic                           comm_led,              // yellow comm led
    output logic                           irq                    // level interrupt
);
    import tcm_pkg::*;

    localparam logic [31:0] TEST_LAST = 32'(SELFTEST_CYC - 1);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic       a_s;
    logic       b_s;
    logic       jumper_s;
    logic       fb_s;

    tcm_sync #(.WIDTH(4)) u_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in ({stage_off_fb, bypass_jumper, torque_cutoff_in_b, torque_cutoff_in_a}),
        .sync_out (pins_s)
    ); // [RQ11]

    assign a_s      = pins_s[0];
    assign b_s      = pins_s[1];
    assign jumper_s = pins_s[2];
    assign fb_s     = pins_s[3];

    // ------------------------------------------------------------
    // blink rates
    // ------------------------------------------------------------
    logic st_on;
    logic st_off;
    logic cm_on;
    logic cm_off;

    tcm_blink #(.PERIOD(STATUS_CYC)) u_status_blink (
        .clock      (clock),
        .reset      (reset),
        .mostly_on  (st_on),
        .mostly_off (st_off)
    );

    tcm_blink #(.PERIOD(COMM_CYC)) u_comm_blink (
        .clock      (clock),
        .reset      (reset),
        .mostly_on  (cm_on),
        .mostly_off (cm_off)
    );

    // ------------------------------------------------------------
    // registers over apb
    // ------------------------------------------------------------
    logic             cfg_enable;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic             next_cfg_enable;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_en;
    logic [31:0]      next_prdata;
    logic             next_irq;
    logic             wr_access;
    logic             mapped;
    logic [IRQ_W-1:0] events;
    logic [31:0]      status_word;
    tcm_test_t        test_state;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == CTRL_OFFSET) || (a == STATUS_OFFSET) || (a == IRQ_STATUS_OFFSET)
                 || (a == IRQ_ENABLE_OFFSET) || (a == IRQ_CLEAR_OFFSET);
    endfunction

    // the apb slave never waits; unmapped addresses answer with an error
    assign pready    = 1'b1;
    assign mapped    = is_mapped(paddr);
    assign pslverr   = psel && penable && !mapped;
    assign wr_access = psel && penable && pwrite && mapped;

    always_comb
    begin
        status_word                = 32'h0;
        status_word[ST_MOTOR_BIT]  = motor_enable;
        status_word[ST_ALARM_BIT]  = cutoff_mismatch_alarm;
        status_word[ST_PASS_BIT]   = test_state == TCM_TEST_PASS;
        status_word[ST_FAIL_BIT]   = test_state == TCM_TEST_FAIL;
        status_word[ST_RUN_BIT]    = test_state == TCM_TEST_RUN;
        status_word[ST_ACTIVE_BIT] = cfg_enable && !jumper_s;
        status_word[ST_IN_A_BIT]   = a_s;
        status_word[ST_IN_B_BIT]   = b_s;
        next_cfg_enable = cfg_enable;
        next_irq_en     = irq_en;
        next_irq_stat   = irq_stat;
        if (wr_access && paddr == CTRL_OFFSET)
            next_cfg_enable = pwdata[CTRL_ENABLE_BIT]; // [RQ6]
        if (wr_access && paddr == IRQ_ENABLE_OFFSET)
            next_irq_en = pwdata[IRQ_W-1:0];
        if (wr_access && paddr == IRQ_CLEAR_OFFSET)
            next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
        // a new event wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_en);
        // read data is captured in the setup cycle, valid in the access phase
        next_prdata   = prdata;
        if (psel && !penable)
        begin
            case (paddr)
                CTRL_OFFSET:       next_prdata = {31'h0, cfg_enable};
                STATUS_OFFSET:     next_prdata = status_word;
                IRQ_STATUS_OFFSET: next_prdata = {29'h0, irq_stat};
                IRQ_ENABLE_OFFSET: next_prdata = {29'h0, irq_en};
                default:           next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cfg_enable <= CTRL_ENABLE_RESET;
            irq_en     <= IRQ_ENABLE_RESET;
            irq_stat   <= 3'h0;
            prdata     <= 32'h0;
            irq        <= 1'b0;
        end
        else
        begin
            cfg_enable <= next_cfg_enable;
            irq_en     <= next_irq_en;
            irq_stat   <= next_irq_stat;
            prdata     <= next_prdata;
            irq        <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // self-test and cutoff decision
    // ------------------------------------------------------------
    logic        active;
    logic        both_hi;
    logic        both_hi_q;
    logic        test_req;
    logic        permit;
    logic        test_ok;
    logic [31:0] test_cnt;
    tcm_test_t   next_test_state;
    logic        next_test_ok;
    logic [31:0] next_test_cnt;
    logic        next_motor;
    logic        next_alarm;

    // with the jumper fitted or the function off the inputs are ignored
    assign active   = cfg_enable && !jumper_s;   // [RQ6]
    assign both_hi  = a_s && b_s;
    assign test_req = active && both_hi && !both_hi_q; // [RQ2]
    assign permit   = !active || both_hi;        // [RQ1] [RQ5]

    always_comb
    begin
        next_test_state = test_state;
        next_test_ok    = test_ok;
        next_test_cnt   = test_cnt;
        case (test_state)
            TCM_TEST_RUN:
            begin
                // the stage is held off while testing and must report off throughout
                // the first two cycles after reset still show the synchroniser's reset level
                next_test_ok  = test_ok && (fb_s || test_cnt < 32'h2);
                next_test_cnt = test_cnt + 32'h1;
                if (test_cnt == TEST_LAST)
                    next_test_state = (test_ok && fb_s) ? TCM_TEST_PASS : TCM_TEST_FAIL; // [RQ3]
            end
            TCM_TEST_PASS, TCM_TEST_FAIL:
            begin
                if (test_req)
                begin
                    next_test_state = TCM_TEST_RUN; // [RQ2]
                    next_test_ok    = 1'b1;
                    next_test_cnt   = 32'h0;
                end
            end
            default:
                next_test_state = TCM_TEST_FAIL;
        endcase
        // a both-high rise restarts the test, so the old pass must not energise the stage
        next_motor = (test_state == TCM_TEST_PASS) && permit && !test_req; // [RQ2] [RQ3] [RQ4]
        next_alarm = active && (a_s ^ b_s);                   // [RQ5]
        events                   = '0;
        events[IRQ_MISMATCH_BIT] = next_alarm && !cutoff_mismatch_alarm;
        events[IRQ_FAIL_BIT]     = test_state == TCM_TEST_RUN && next_test_state == TCM_TEST_FAIL;
        events[IRQ_PASS_BIT]     = test_state == TCM_TEST_RUN && next_test_state == TCM_TEST_PASS;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            test_state            <= TCM_TEST_RUN; // power-on test [RQ2]
            test_ok               <= 1'b1;
            test_cnt              <= 32'h0;
            both_hi_q             <= 1'b0;
            motor_enable          <= 1'b0;
            cutoff_mismatch_alarm <= 1'b0;
        end
        else
        begin
            test_state            <= next_test_state;
            test_ok               <= next_test_ok;
            test_cnt              <= next_test_cnt;
            both_hi_q             <= both_hi;
            motor_enable          <= next_motor;
            cutoff_mismatch_alarm <= next_alarm;
        end
    end

    // ------------------------------------------------------------
    // indicator leds
    // ------------------------------------------------------------
    logic next_comm;
    logic next_green;
    logic next_red;
    logic fault;

    assign fault = cutoff_mismatch_alarm || test_state == TCM_TEST_FAIL;

    always_comb
    begin
        case ({usb_active, can_enabled})
            2'b00:   next_comm = 1'b0;   // [RQ7]
            2'b10:   next_comm = 1'b1;   // [RQ7]
            2'b01:   next_comm = cm_on;  // [RQ7]
            default: next_comm = cm_off; // [RQ7]
        endcase
        next_green = !fault && st_off; // [RQ8]
        next_red   = fault && st_on;   // [RQ8]
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            comm_led         <= 1'b0;
            status_led_green <= 1'b0;
            status_led_red   <= 1'b0;
            power_led        <= 1'b0;
        end
        else
        begin
            comm_led         <= next_comm;
            status_led_green <= next_green;
            status_led_red   <= next_red;
            power_led        <= 1'b1; // [RQ9]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_both_rise;
        (active && !both_hi) ##1 (active && both_hi);
    endsequence

    property p_need_both;
        (active && !both_hi) |=> !motor_enable;
    endproperty
    a_need_both: assert property (p_need_both) else $error("motor on without both inputs"); // [RQ1]

    property p_retest;
        s_both_rise |=> test_state == TCM_TEST_RUN;
    endproperty
    a_retest: assert property (p_retest) else $error("no self-test on both-high rise"); // [RQ2]

    property p_test_ends;
        (test_state == TCM_TEST_RUN && test_cnt == TEST_LAST) |=> test_state != TCM_TEST_RUN;
    endproperty
    a_test_ends: assert property (p_test_ends) else $error("self-test overran"); // [RQ2]

    property p_req_off;
        test_req |=> !motor_enable;
    endproperty
    a_req_off: assert property (p_req_off) else $error("motor on at self-test start"); // [RQ3]

    property p_after_pass;
        motor_enable |-> $past(test_state) == TCM_TEST_PASS;
    endproperty
    a_after_pass: assert property (p_after_pass) else $error("motor on without passed test"); // [RQ3]

    property p_fail_off;
        (test_state == TCM_TEST_FAIL) [*2] |-> !motor_enable;
    endproperty
    a_fail_off: assert property (p_fail_off) else $error("motor on after failed test"); // [RQ4]

    property p_alarm;
        (active && (a_s != b_s)) |=> cutoff_mismatch_alarm && !motor_enable;
    endproperty
    a_alarm: assert property (p_alarm) else $error("mismatch not alarmed"); // [RQ5]

    property p_low_quiet;
        (!a_s && !b_s) |=> !cutoff_mismatch_alarm;
    endproperty
    a_low_quiet: assert property (p_low_quiet) else $error("alarm with both inputs low"); // [RQ5]

    property p_bypass;
        (!active && test_state == TCM_TEST_PASS) |=> motor_enable && !cutoff_mismatch_alarm;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not permit motor"); // [RQ6]

    property p_comm;
        (usb_active && !can_enabled) ##1 (usb_active && !can_enabled) |-> comm_led;
    endproperty
    a_comm: assert property (p_comm) else $error("comm led not steady on"); // [RQ7]

    property p_status;
        (test_state == TCM_TEST_FAIL) |=> !status_led_green;
    endproperty
    a_status: assert property (p_status) else $error("green status during fault"); // [RQ8]

    property p_power;
        !$past(reset) |-> power_led;
    endproperty
    a_power: assert property (p_power) else $error("power led off"); // [RQ9]

    property p_sync;
        (!$past(reset, 1) && !$past(reset, 2) && !$past(reset, 3))
            |-> a_s == $past(torque_cutoff_in_a, 2) && b_s == $past(torque_cutoff_in_b, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("input not two flops deep"); // [RQ11]
endmodule
`default_nettype wire

// File: hw/tcm_pkg.sv
// constants shared by the torque cutoff monitor and its helpers
package tcm_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ             = 25_000_000;
    localparam int unsigned SELFTEST_TIME_US   = 1000;
    localparam int unsigned SELFTEST_CYCLES    = SELFTEST_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STATUS_PERIOD_MS   = 2000;
    localparam int unsigned STATUS_PERIOD_CYC  = STATUS_PERIOD_MS * (CLK_HZ / 1000);
    localparam int unsigned COMM_PERIOD_MS     = 1000;
    localparam int unsigned COMM_PERIOD_CYC    = COMM_PERIOD_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W             = 8;
    localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
    localparam logic [7:0]  IRQ_STATUS_OFFSET  = 8'h08;
    localparam logic [7:0]  IRQ_ENABLE_OFFSET  = 8'h0C;
    localparam logic [7:0]  IRQ_CLEAR_OFFSET   = 8'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_ENABLE_BIT    = 0;
    localparam int unsigned ST_MOTOR_BIT       = 0;
    localparam int unsigned ST_ALARM_BIT       = 1;
    localparam int unsigned ST_PASS_BIT        = 2;
    localparam int unsigned ST_FAIL_BIT        = 3;
    localparam int unsigned ST_RUN_BIT         = 4;
    localparam int unsigned ST_ACTIVE_BIT      = 5;
    localparam int unsigned ST_IN_A_BIT        = 6;
    localparam int unsigned ST_IN_B_BIT        = 7;
    localparam int unsigned IRQ_W              = 3;
    localparam int unsigned IRQ_MISMATCH_BIT   = 0;
    localparam int unsigned IRQ_FAIL_BIT       = 1;
    localparam int unsigned IRQ_PASS_BIT       = 2;
    localparam logic        CTRL_ENABLE_RESET  = 1'b0;
    localparam logic [2:0]  IRQ_ENABLE_RESET   = 3'h0;

    typedef enum logic [1:0] {TCM_TEST_RUN, TCM_TEST_PASS, TCM_TEST_FAIL} tcm_test_t;
endpackage

// File: hw/tcm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module tcm_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clock,    // system clock
    input  wire logic             reset,    // async, active high
    input  wire logic [WIDTH-1:0] async_in, // raw pins
    output logic      [WIDTH-1:0] sync_out  // safe to use
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// File: hw/tcm_blink.sv
// free running period counter giving mostly-on and mostly-off blink levels
`timescale 1ns/10ps
`default_nettype none
module tcm_blink #(
    parameter int unsigned PERIOD = 50_000_000
) (
    input  wire logic clock,      // system clock
    input  wire logic reset,      // async, active high
    output logic      mostly_on,  // high for three quarters of a period
    output logic      mostly_off  // high for one quarter of a period
);
    localparam logic [31:0] LAST    = 32'(PERIOD - 1);
    localparam logic [31:0] QUARTER = 32'(PERIOD / 4);
    localparam logic [31:0] THREEQ  = 32'((PERIOD / 4) * 3);

    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_on;
    logic        next_off;

    always_comb
    begin
        next_count = (count == LAST) ? 32'h0 : count + 32'h1;
        next_on    = next_count < THREEQ;
        next_off   = next_count < QUARTER;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            count      <= 32'h0;
            mostly_on  <= 1'b0;
            mostly_off <= 1'b0;
        end
        else
        begin
            count      <= next_count;
            mostly_on  <= next_on;
            mostly_off <= next_off;
        end
    end
endmodule
`default_nettype wire

// File: tb/tcm_safety_model.sv
// model of the external safety circuit that drives both cutoff inputs
`timescale 1ns/10ps
`default_nettype none
module tcm_safety_model (
    input  wire logic [1:0] pins_req,           // requested levels {a, b}
    input  wire logic       fault_split,        // let the two lines differ
    output logic            torque_cutoff_in_a, // cutoff pin a
    output logic            torque_cutoff_in_b  // cutoff pin b
);
    // a healthy circuit moves both lines together; a split only shows a wiring fault on command
    always_comb
    begin
        torque_cutoff_in_a = pins_req[1];
        torque_cutoff_in_b = fault_split ? pins_req[0] : pins_req[1];
    end
endmodule
`default_nettype wire

// File: tb/test_tcm_monitor.sv
// self-checking testbench for the torque cutoff monitor
`timescale 1ns/10ps
`default_nettype none
module test_tcm_monitor;
    import tcm_pkg::*;
    localparam int unsigned ST = 16;
    localparam int unsigned SC = 40;
    localparam int unsigned CC = 20;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pins_req = 2'h0;
    logic        split = 1'b0;
    logic        pin_a;
    logic        pin_b;
    logic        jumper = 1'b1;
    logic        stage_off_fb = 1'b1;
    logic        usb_active = 1'b0;
    logic        can_enabled = 1'b0;
    logic        motor_enable;
    logic        alarm;
    logic        power_led;
    logic        led_green;
    logic        led_red;
    logic        comm_led;
    logic        irq;
    int          err_count = 0;
    int          num_checks = 0;

    always #20 clock = ~clock;

    tcm_monitor #(.SELFTEST_CYC(ST), .STATUS_CYC(SC), .COMM_CYC(CC)) i_tcm_monitor (
        .clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .torque_cutoff_in_a(pin_a),
        .torque_cutoff_in_b(pin_b), .bypass_jumper(jumper), .stage_off_fb(stage_off_fb),
        .usb_active(usb_active), .can_enabled(can_enabled), .motor_enable(motor_enable),
        .cutoff_mismatch_alarm(alarm), .power_led(power_led), .status_led_green(led_green),
        .status_led_red(led_red), .comm_led(comm_led), .irq(irq));

    tcm_safety_model i_tcm_safety_model (
        .pins_req(pins_req), .fault_split(split), .torque_cutoff_in_a(pin_a), .torque_cutoff_in_b(pin_b));

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // pready is polled each edge; only the watchdog ends a wait on a stuck slave
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        check(what, rd, exp);
        check("pslverr", e, exp_err);
    endtask

    task automatic set_pins(input logic [1:0] v);
        @(posedge clock);
        pins_req <= v;
        split <= v[1] ^ v[0];
        repeat (4) @(negedge clock);
    endtask

    task automatic wait_motor(output int n);
        n = 0;
        while (motor_enable !== 1'b1 && n < 200)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    // sel 0 counts green, 1 the comm led, 2 red
    task automatic count_high(input int sel, input int cyc, output int n);
        n = 0;
        repeat (cyc)
        begin
            @(negedge clock);
            n += (sel == 0) ? led_green : (sel == 1) ? comm_led : led_red;
        end
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_power();
        int n;
        repeat (2) @(negedge clock);
        check("power_led", power_led, 1'b1);
        check("motor during test", motor_enable, 1'b0);
        wait_motor(n);
        check("test length kept", n >= ST, 1'b1);
        check("bypass motor", motor_enable, 1'b1);
        rd_chk("ctrl reset", CTRL_OFFSET, 32'h0, 1'b0);
        rd_chk("irq enable reset", IRQ_ENABLE_OFFSET, 32'h0, 1'b0);
        rd_chk("unmapped", 8'h20, 32'h0, 1'b1);
        $display("test power done");
    endtask

    task automatic t_cutoff();
        int n;
        jumper <= 1'b0;
        wr(CTRL_OFFSET, 32'h1);
        set_pins(2'b00);
        check("motor both low", motor_enable, 1'b0);
        check("alarm both low", alarm, 1'b0);
        set_pins(2'b10);
        check("alarm a only", alarm, 1'b1);
        check("motor a only", motor_enable, 1'b0);
        set_pins(2'b01);
        check("alarm b only", alarm, 1'b1);
        set_pins(2'b11);
        repeat (ST - 4) @(negedge clock);
        check("motor in retest", motor_enable, 1'b0);
        wait_motor(n);
        check("motor after pass", motor_enable, 1'b1);
        rd_chk("status running", STATUS_OFFSET, 32'hE5, 1'b0);
        @(posedge clock);
        pins_req <= 2'b01;
        split <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("motor two edges", motor_enable, 1'b1);
        @(negedge clock);
        check("motor three edges", motor_enable, 1'b0);
        check("alarm three edges", alarm, 1'b1);
        $display("test cutoff done");
    endtask

    task automatic t_irq();
        set_pins(2'b00);
        wr(IRQ_CLEAR_OFFSET, 32'h7);
        wr(IRQ_ENABLE_OFFSET, 32'h1);
        rd_chk("irq enable", IRQ_ENABLE_OFFSET, 32'h1, 1'b0);
        check("irq idle", irq, 1'b0);
        set_pins(2'b10);
        check("irq raised", irq, 1'b1);
        rd_chk("irq status", IRQ_STATUS_OFFSET, 32'h1, 1'b0);
        wr(IRQ_CLEAR_OFFSET, 32'h1);
        @(negedge clock);
        check("irq cleared", irq, 1'b0);
        wr(IRQ_ENABLE_OFFSET, 32'h0);
        set_pins(2'b00);
        set_pins(2'b01);
        check("irq masked", irq, 1'b0);
        $display("test irq done");
    endtask

    task automatic t_fail();
        int n;
        set_pins(2'b00);
        wr(IRQ_CLEAR_OFFSET, 32'h7);
        wr(IRQ_ENABLE_OFFSET, 32'h2);
        stage_off_fb <= 1'b0;
        set_pins(2'b11);
        repeat (ST + 8) @(negedge clock);
        check("motor failed test", motor_enable, 1'b0);
        check("irq test fail", irq, 1'b1);
        count_high(2, SC, n);
        check("red fault blink", n, SC * 3 / 4);
        count_high(0, SC, n);
        check("green off in fault", n, 0);
        @(posedge clock);
        stage_off_fb <= 1'b1;
        set_pins(2'b00);
        set_pins(2'b11);
        wait_motor(n);
        check("motor after retest", motor_enable, 1'b1);
        rd_chk("pass flagged", IRQ_STATUS_OFFSET, 32'h6, 1'b0);
        $display("test fail done");
    endtask

    task automatic t_leds();
        int n;
        logic [1:0] flags;
        int exp_comm [4] = '{0, CC, CC * 3 / 4, CC / 4};
        count_high(1'b0, SC, n);
        check("green quarter blink", n, SC / 4);
        for (int i = 0; i < 4; i++)
        begin
            flags = 2'(i);
            @(posedge clock);
            usb_active <= flags[0];
            can_enabled <= flags[1];
            repeat (3) @(negedge clock);
            count_high(1'b1, CC, n);
            check("comm led", n, exp_comm[i]);
        end
        $display("test leds done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_power();
        t_cutoff();
        t_irq();
        t_fail();
        t_leds();
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
